//--- src/soaec_top.sv
// Purpose: SDI output source choice, audio group placement and contact control.
// Assumes: Video datapaths and audio rate converters are outside; this block steers them.
// Notes:   Word-level stream control; all outputs registered.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// R1 - External reference mode always generates video internally
// R2 - Only HD or 3G accepted as reference
// R3 - All eight channels embedded continuously
// R4 - Nine-choice setting maps audio to groups
// R5 - Four inputs, two channels each
// R6 - Embed into external or internal stream
// R7 - Overwrite embedded groups, pass others unchanged
// R8 - Source switch glitch is tolerated
// R9 - Contact input switches embedding on/off
// R10 - Indicator follows validity, polarity configurable
// R11 - Coax input active only when selected
// R12 - Optical output mirrors coax output always
// R13 - HD and 3G inputs; SD refused
// R14 - Output is HD or 3G
// R15 - Rate-converted audio targets 24-bit 48 kHz
// R16 - No input: switch to internal image
// R17 - Gray for seconds before stored image
// R18 - One input selected by configuration only
// R19 - Contact active only while held low
// R20 - Contact synchronised and debounced first
module soaec_top
#(
  parameter int unsigned GRAY_CYCLES = soaec_pkg::GRAY_CYC,      // Gray hold cycles.
  parameter int unsigned DB_CYCLES   = soaec_pkg::DEBOUNCE_CYC   // Debounce cycles.
)
(
  input  wire logic                          clk_i,        // Clock, 100 MHz.
  input  wire logic                          rst_i,        // Synchronous reset.
  input  wire logic                          ce_i,         // Clock enable.
  // Wishbone slave.
  input  wire logic                          cyc_i,        // Bus cycle.
  input  wire logic                          stb_i,        // Strobe.
  input  wire logic                          we_i,         // Write enable.
  input  wire logic [soaec_pkg::ADDR_W-1:0]  adr_i,        // Byte address.
  input  wire logic [3:0]                    sel_i,        // Byte selects.
  input  wire logic [soaec_pkg::DATA_W-1:0]  dat_i,        // Write data.
  output logic      [soaec_pkg::DATA_W-1:0]  dat_o,        // Read data.
  output logic                               ack_o,        // Acknowledge.
  // Video inputs, status from receivers.
  input  wire logic                          coax_valid_i, // Coax receiver locked.
  input  wire logic [1:0]                    coax_rate_i,  // Coax rate code.
  input  wire logic                          opt_valid_i,  // Optical receiver locked.
  input  wire logic [1:0]                    opt_rate_i,   // Optical rate code.
  input  wire logic [9:0]                    vid_word_i,   // Selected input word.
  input  wire logic [2:0]                    vid_group_i,  // Audio group tag of word, 0=none.
  input  wire logic [9:0]                    gen_word_i,   // Internal image word.
  input  wire logic [9:0]                    gray_word_i,  // Internal gray word.
  input  wire logic [9:0]                    aud_word_i,   // Embedder word, eight channels.
  input  wire logic                          aud_locked_i, // Rate converters locked at 48 kHz.
  input  wire logic                          embed_contact_n_i, // Contact, low closed.
  // Outputs.
  output logic                               coax_rx_en_o, // Enable coax receiver.
  output logic                               opt_rx_en_o,  // Enable optical receiver.
  output logic [9:0]                         coax_tx_o,    // Coax output word.
  output logic [9:0]                         opt_tx_o,     // Optical output word.
  output logic                               tx_is3g_o,    // Output at 3G rate.
  output logic                               gen_lock_o,   // Generator locks to reference.
  output logic [3:0]                         aud_group_o,  // Groups chosen for embedding.
  output logic                               embed_on_o,   // Embedding enabled.
  output logic                               input_valid_indicator_output_o // Indicator.
);
  import soaec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Parameter checks.
  initial
  begin
    if (GRAY_CYCLES < 1) $error("gray hold must be at least one cycle");
    if (DB_CYCLES < 1) $error("debounce must be at least one cycle");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Group map: choice 0..3 single group, 4..6 adjacent pairs, 7..8 spread pairs.
  function automatic logic [3:0] group_map(input logic [3:0] choice);
    logic [3:0] m;
    m = 4'h1;
    case (choice)
      4'h0:    m = 4'h1;  // Group 1.
      4'h1:    m = 4'h2;  // Group 2.
      4'h2:    m = 4'h4;  // Group 3.
      4'h3:    m = 4'h8;  // Group 4.
      4'h4:    m = 4'h3;  // Groups 1 and 2.
      4'h5:    m = 4'h6;  // Groups 2 and 3.
      4'h6:    m = 4'hC;  // Groups 3 and 4.
      4'h7:    m = 4'h5;  // Groups 1 and 3.
      4'h8:    m = 4'hA;  // Groups 2 and 4.
      default: m = 4'h1;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State.
  typedef struct packed
  {
    logic [3:0]  ctrl;       // Control bits.
    logic [3:0]  group;      // Group choice.
    soaec_src_t  src;        // Output source.
    logic [31:0] gray_cnt;   // Gray hold counter.
    logic        is3g;       // Learned output rate.
    logic [31:0] rdata;      // Bus read data.
    logic        ack;        // Bus acknowledge.
    logic        rx_coax;    // Coax receiver enable.
    logic        rx_opt;     // Optical receiver enable.
    logic [9:0]  tx;         // Output word.
    logic        lock;       // Generator reference lock.
    logic [3:0]  grp_out;    // Groups chosen for embedding.
    logic        emb;        // Embedding on.
    logic        ind;        // Indicator.
    logic        valid;      // Selected input valid.
  } soaec_st_t;
  soaec_st_t st;       // Current state.
  soaec_st_t next_st;  // Next state.

  soaec_db_if db ();   // Contact carrier.
  assign db.raw_n = embed_contact_n_i;

  // Contact filter.
  soaec_debounce
  #(
    .CYC (DB_CYCLES)
  )
  u_db
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .db    (db)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Combinational next state.
  always_comb
  begin
    logic       sel_valid;
    logic [1:0] sel_rate;
    logic       hit;
    logic [3:0] gmask;
    logic       in_grp;
    sel_valid = 1'b0;
    sel_rate  = RATE_SD;
    hit       = 1'b0;
    gmask     = 4'h0;
    in_grp    = 1'b0;
    next_st   = st;

    // R18 single selection
    // The choice comes from the control bit only, never from signal presence.
    // R11 coax enable gated
    next_st.rx_coax = st.ctrl[CTRL_INEN] && !st.ctrl[CTRL_OPTSEL];
    next_st.rx_opt  = st.ctrl[CTRL_INEN] && st.ctrl[CTRL_OPTSEL];
    if (st.ctrl[CTRL_OPTSEL])
    begin
      sel_valid = st.rx_opt && opt_valid_i;
      sel_rate  = opt_rate_i;
    end
    else
    begin
      sel_valid = st.rx_coax && coax_valid_i;
      sel_rate  = coax_rate_i;
    end
    // R13 SD refused
    // R2 digital reference only
    if ((sel_rate != RATE_HD) && (sel_rate != RATE_3G))
    begin
      sel_valid = 1'b0;
    end
    next_st.valid = sel_valid;
    // R14 learn output rate
    if (sel_valid)
    begin
      next_st.is3g = (sel_rate == RATE_3G);
    end

    // Output source sequencing.
    case (st.src)
      SRC_PASS:
      begin
        // R16 lost input
        if (!sel_valid)
        begin
          next_st.src      = SRC_GRAY;
          next_st.gray_cnt = '0;
        end
        // R1 reference only
        else if (st.ctrl[CTRL_EXTREF])
        begin
          next_st.src = SRC_IMG;
        end
      end
      SRC_GRAY:
      begin
        // R17 gray hold
        if (sel_valid && !st.ctrl[CTRL_EXTREF])
        begin
          next_st.src = SRC_PASS;
        end
        else if (sel_valid || (st.gray_cnt >= 32'(GRAY_CYCLES - 1)))
        begin
          next_st.src = SRC_IMG;
        end
        else
        begin
          next_st.gray_cnt = st.gray_cnt + 32'h1;
        end
      end
      SRC_IMG:
      begin
        // R8 abrupt switch tolerated
        if (sel_valid && !st.ctrl[CTRL_EXTREF])
        begin
          next_st.src = SRC_PASS;
        end
      end
      default:
      begin
        next_st.src = SRC_IMG;
      end
    endcase
    // R1 generator locks to input timing
    next_st.lock = sel_valid && st.ctrl[CTRL_EXTREF];

    // R9 contact switches embedding
    // R19 held low only
    // R20 debounced contact
    next_st.emb = !db.active;
    // R4 group choice
    gmask = group_map(st.group);
    next_st.grp_out = gmask;
    if (vid_group_i != 3'h0)
    begin
      in_grp = gmask[2'(vid_group_i - 3'h1)];
    end

    // R6 embed into either stream
    // R3 continuous embedding
    // R5 R15 eight rate-converted channels
    case (st.src)
      SRC_PASS:
      begin
        // R7 overwrite or pass
        if (st.emb && aud_locked_i && in_grp)
        begin
          next_st.tx = aud_word_i;
        end
        else
        begin
          next_st.tx = vid_word_i;
        end
      end
      SRC_GRAY:
        next_st.tx = (st.emb && in_grp) ? aud_word_i : gray_word_i;
      default:
        next_st.tx = (st.emb && in_grp) ? aud_word_i : gen_word_i;
    endcase

    // R10 indicator polarity
    next_st.ind = sel_valid ^ st.ctrl[CTRL_IND_POL];

    // Wishbone slave: answer one cycle after the strobe, drop ack next cycle.
    next_st.ack = 1'b0;
    hit = cyc_i && stb_i && !st.ack;
    if (hit)
    begin
      next_st.ack   = 1'b1;
      next_st.rdata = '0;
      case (adr_i)
        REG_CTRL:
        begin
          next_st.rdata[3:0] = st.ctrl;
          if (we_i && sel_i[0])
          begin
            next_st.ctrl = dat_i[3:0];
          end
        end
        REG_STATUS:
        begin
          next_st.rdata[ST_VALID]  = st.valid;
          next_st.rdata[ST_EXTSRC] = (st.src == SRC_PASS);
          next_st.rdata[ST_GRAY]   = (st.src == SRC_GRAY);
          next_st.rdata[ST_EMBED]  = st.emb;
          next_st.rdata[ST_IS3G]   = st.is3g;
        end
        REG_GROUP:
        begin
          next_st.rdata[3:0] = st.group;
          // Choices beyond the last are ignored.
          if (we_i && sel_i[0] && (dat_i[3:0] <= GROUP_MAX))
          begin
            next_st.group = dat_i[3:0];
          end
        end
        default:
        begin
          next_st.rdata = '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st       <= '0;
      st.ctrl  <= CTRL_RST;
      st.group <= GROUP_RST;
      st.src   <= SRC_IMG;
      st.grp_out <= 4'h1;
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state.
  assign dat_o        = st.rdata;
  assign ack_o        = st.ack;
  assign coax_rx_en_o = st.rx_coax;
  assign opt_rx_en_o  = st.rx_opt;
  assign coax_tx_o    = st.tx;
  // R12 optical mirrors coax
  assign opt_tx_o     = st.tx;
  assign tx_is3g_o    = st.is3g;
  assign gen_lock_o   = st.lock;
  assign aud_group_o  = st.grp_out;
  assign embed_on_o   = st.emb;
  assign input_valid_indicator_output_o = st.ind;
endmodule

//--- src/soaec_pkg.sv
// Purpose: Shared constants and types for the SDI output audio embed control block.
// Assumes: One 100 MHz clock, synchronous active-high reset, classic Wishbone slave.
// Notes:   Register offsets are byte addresses of aligned 32-bit words.
package soaec_pkg;
  // Wishbone widths.
  localparam int unsigned ADDR_W = 8;    // Byte address width.
  localparam int unsigned DATA_W = 32;   // Data width.
  // Register byte offsets.
  localparam logic [7:0] REG_CTRL   = 8'h00;  // Control register.
  localparam logic [7:0] REG_STATUS = 8'h04;  // Status register.
  localparam logic [7:0] REG_GROUP  = 8'h08;  // Group-map choice register.
  // Control field positions.
  localparam int unsigned CTRL_EXTREF  = 0;  // External-reference mode.
  localparam int unsigned CTRL_OPTSEL  = 1;  // Optical input selected when set.
  localparam int unsigned CTRL_INEN    = 2;  // Selected input enabled.
  localparam int unsigned CTRL_IND_POL = 3;  // Indicator active on invalid input.
  // Reset values.
  localparam logic [3:0] CTRL_RST  = 4'h0;   // All control bits clear.
  localparam logic [3:0] GROUP_RST = 4'h0;   // Choice 0: audio into group 1.
  localparam logic [3:0] GROUP_MAX = 4'h8;   // Nine choices, 0 to 8.
  // Status field positions.
  localparam int unsigned ST_VALID  = 0;  // Selected input valid.
  localparam int unsigned ST_EXTSRC = 1;  // Output follows external stream.
  localparam int unsigned ST_GRAY   = 2;  // Gray fill shown.
  localparam int unsigned ST_EMBED  = 3;  // Embedding on.
  localparam int unsigned ST_IS3G   = 4;  // Learned output rate is 3G.
  // Timing.
  localparam int unsigned CLK_MHZ       = 100;   // Clock rate in MHz.
  localparam int unsigned GRAY_MS       = 3000;  // Gray hold time in ms.
  localparam int unsigned DEBOUNCE_US   = 10000; // Contact debounce time in us.
  localparam int unsigned GRAY_CYC      = GRAY_MS * 1000 * CLK_MHZ;
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * CLK_MHZ;
  // Input rate codes.
  localparam logic [1:0] RATE_SD = 2'h0;  // Standard definition, refused.
  localparam logic [1:0] RATE_HD = 2'h1;  // HD rate.
  localparam logic [1:0] RATE_3G = 2'h2;  // 3G rate.
  // Output source selection, one-hot.
  typedef enum logic [2:0]
  {
    SRC_PASS = 3'h1,  // Pass external stream.
    SRC_GRAY = 3'h2,  // Internal gray fill.
    SRC_IMG  = 3'h4   // Internal stored image.
  } soaec_src_t;
endpackage

//--- src/soaec_db_if.sv
// Purpose: Carries the contact level and its debounced result between modules.
// Assumes: Single clock domain.
// Notes:   Used between the top and the debouncer only.
`timescale 1ns/1ps
interface soaec_db_if;
  logic raw_n;     // Raw contact level, low when closed.
  logic active;    // Debounced closure, high while held closed.
  modport filt
  (
    input  raw_n,
    output active
  );
  modport user
  (
    output raw_n,
    input  active
  );
endinterface

//--- src/soaec_debounce.sv
// Purpose: Synchronise and debounce the contact input.
// Assumes: Input may be asynchronous to clk_i.
// Notes:   Output follows level only; no latching.
`timescale 1ns/1ps
module soaec_debounce
#(
  parameter int unsigned CYC = soaec_pkg::DEBOUNCE_CYC  // Stable cycles required.
)
(
  input  wire logic clk_i,   // Clock.
  input  wire logic rst_i,   // Synchronous reset.
  input  wire logic ce_i,    // Clock enable.
  soaec_db_if.filt  db       // Contact carrier.
);
  import soaec_pkg::*;
  initial
  begin
    if (CYC < 1) $error("debounce count must be at least one");
  end
  typedef struct packed
  {
    logic        s1;     // First synchroniser stage.
    logic        s2;     // Second synchroniser stage.
    logic [31:0] cnt;    // Stability counter.
    logic        act;    // Debounced active level.
  } soaec_db_st_t;
  soaec_db_st_t st;       // Current state.
  soaec_db_st_t next_st;  // Next state.
  // Count while the synchronised level differs from the held result.
  always_comb
  begin
    next_st = st;
    next_st.s1 = db.raw_n;
    next_st.s2 = st.s1;
    if ((!st.s2) == st.act)
    begin
      next_st.cnt = '0;
    end
    else if (st.cnt >= 32'(CYC - 1))
    begin
      // Active only while low, taken after a stable interval.
      next_st.act = !st.s2;
      next_st.cnt = '0;
    end
    else
    begin
      next_st.cnt = st.cnt + 32'h1;
    end
  end
  // State register with clock enable.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      st <= '{s1: 1'b1, s2: 1'b1, cnt: 32'h0, act: 1'b0};
    end
    else if (ce_i)
    begin
      st <= next_st;
    end
  end
  assign db.active = st.act;
endmodule

//--- test/soaec_checker.sv
// Purpose: Port-level assertions for the output control block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Bound to soaec_top from the bench top file.
`timescale 1ns/1ps
module soaec_checker
  import soaec_pkg::*;
#(
  parameter int unsigned DB_CYCLES = 4  // Debounce cycles of the design.
)
(
  input wire logic                  clk_i,             // Clock.
  input wire logic                  rst_i,             // Reset.
  input wire logic                  ce_i,              // Clock enable.
  input wire logic                  cyc_i,             // Bus cycle.
  input wire logic                  stb_i,             // Strobe.
  input wire logic                  we_i,              // Write enable.
  input wire logic [ADDR_W-1:0]     adr_i,             // Address.
  input wire logic                  ack_o,             // Acknowledge.
  input wire logic                  coax_rx_en_o,      // Coax receiver enable.
  input wire logic                  opt_rx_en_o,       // Optical receiver enable.
  input wire logic [9:0]            coax_tx_o,         // Coax word.
  input wire logic [9:0]            opt_tx_o,          // Optical word.
  input wire logic [3:0]            aud_group_o,       // Group mask.
  input wire logic                  embed_on_o,        // Embedding on.
  input wire logic                  embed_contact_n_i  // Contact, low closed.
);
  localparam int unsigned LIM = DB_CYCLES + 6;  // Settle margin for the contact.
  int unsigned lo_cnt;  // Consecutive closed cycles.
  int unsigned hi_cnt;  // Consecutive open cycles.
  logic        tk;      // Control write taken.
  assign tk = cyc_i && stb_i && we_i && !ack_o && ce_i && (adr_i == REG_CTRL);
  ////////////////////////////////////////////////////////////////////////////
  // Count how long the contact has held one level.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !embed_contact_n_i)
      hi_cnt <= 0;
    else if (ce_i && hi_cnt < 1000)
      hi_cnt <= hi_cnt + 1;
    if (rst_i || embed_contact_n_i)
      lo_cnt <= 0;
    else if (ce_i && lo_cnt < 1000)
      lo_cnt <= lo_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_opt_mirror;
    @(posedge clk_i) disable iff (rst_i) opt_tx_o == coax_tx_o;
  endproperty
  a_opt_mirror: assert property (p_opt_mirror)
    else $error("optical word differs from coax word");
  property p_rx_excl;
    @(posedge clk_i) disable iff (rst_i) !(coax_rx_en_o && opt_rx_en_o);
  endproperty
  a_rx_excl: assert property (p_rx_excl)
    else $error("both receivers enabled");
  property p_rx_cfg;
    @(posedge clk_i) disable iff (rst_i)
      $changed({coax_rx_en_o, opt_rx_en_o}) |-> $past(tk, 1) || $past(tk, 2);
  endproperty
  a_rx_cfg: assert property (p_rx_cfg)
    else $error("receiver enable changed without control write");
  property p_ack_answer;
    @(posedge clk_i) disable iff (rst_i) cyc_i && stb_i && !ack_o && ce_i |=> ack_o;
  endproperty
  a_ack_answer: assert property (p_ack_answer)
    else $error("bus request not answered next cycle");
  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  property p_group_mask;
    @(posedge clk_i) disable iff (rst_i)
      aud_group_o inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h5, 4'hA};
  endproperty
  a_group_mask: assert property (p_group_mask)
    else $error("group mask not one of the nine choices");
  property p_ce_freeze;
    @(posedge clk_i) disable iff (rst_i)
      !ce_i |=> $stable(coax_tx_o) && $stable(embed_on_o) && $stable(aud_group_o);
  endproperty
  a_ce_freeze: assert property (p_ce_freeze)
    else $error("outputs moved while clock enable low");
  property p_contact_off;
    @(posedge clk_i) disable iff (rst_i) lo_cnt >= LIM |-> !embed_on_o;
  endproperty
  a_contact_off: assert property (p_contact_off)
    else $error("embedding on while contact held closed");
  property p_contact_on;
    @(posedge clk_i) disable iff (rst_i) hi_cnt >= LIM |-> embed_on_o;
  endproperty
  a_contact_on: assert property (p_contact_on)
    else $error("embedding off while contact open");
endmodule

//--- test/soaec_src_model.sv
// Purpose: Upstream source: receiver status, rate, words and group tags.
// Assumes: Driven from bench controls; outputs change after rising edges.
// Notes:   With neither input present the word toggles, never the last one.
`timescale 1ns/1ps
module soaec_src_model
#(
  parameter logic [9:0] VID_W = 10'h155  // Word sent while present.
)
(
  input  wire logic       clk_i,         // Clock.
  input  wire logic       present_i,     // Coax source connected.
  input  wire logic       opt_present_i, // Optical source connected.
  input  wire logic [1:0] rate_i,        // Rate code sent.
  input  wire logic [2:0] tag_i,         // Group tag of the word.
  output logic            coax_valid_o,  // Coax locked.
  output logic [1:0]      coax_rate_o,   // Coax rate.
  output logic            opt_valid_o,   // Optical locked.
  output logic [1:0]      opt_rate_o,    // Optical rate.
  output logic [9:0]      vid_word_o,    // Selected word.
  output logic [2:0]      vid_group_o    // Group tag.
);
  logic [9:0] ph = 10'h3C3;  // Idle pattern.
  // Register every line after the edge, like a receiver would.
  always_ff @(posedge clk_i)
  begin
    ph           <= ~ph;
    coax_valid_o <= present_i;
    opt_valid_o  <= opt_present_i;
    coax_rate_o  <= rate_i;
    opt_rate_o   <= rate_i;
    vid_word_o   <= (present_i || opt_present_i) ? VID_W : ph;
    vid_group_o  <= tag_i;
  end
endmodule

//--- test/soaec_top_test.sv
// Purpose: Self-checking bench for soaec_top.
// Assumes: Short gray and debounce counts.
// Notes:   Reset readback and table loops first, then hand-written cases.
`timescale 1ns/1ps
module soaec_top_test;
  import soaec_pkg::*;
  localparam int unsigned GC = 20;  // Gray hold cycles.
  localparam int unsigned DC = 4;   // Debounce cycles.
  localparam logic [9:0] WA = 10'h2AA, WG = 10'h0F0, WY = 10'h30F, WV = 10'h155;
  logic clk, rst, ce, cyc, stb, we, ack, pres, opres, con_n;
  logic [7:0] adr;
  logic [3:0] sel, agrp;
  logic [31:0] dat, dat_o, rd;
  logic [1:0] rate, cr, orr;
  logic [2:0] tag, vg;
  logic [9:0] vw, ctx, otx, snap;
  logic cv, ov, crx, orx, is3g, glk, eon, ind, alk;
  int n_fail, num_checks, cycles;
  logic [3:0] tbl [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h5, 4'hA};
  logic [6:0] t2 [6] = '{7'h00, 7'h25, 7'h64, 7'h41, 7'h32, 7'h73};
  soaec_src_model #(.VID_W(WV)) src_u (.clk_i(clk), .present_i(pres),
    .opt_present_i(opres), .rate_i(rate), .tag_i(tag), .coax_valid_o(cv),
    .coax_rate_o(cr), .opt_valid_o(ov), .opt_rate_o(orr), .vid_word_o(vw), .vid_group_o(vg));
  soaec_top #(.GRAY_CYCLES(GC), .DB_CYCLES(DC)) dut_u (.clk_i(clk), .rst_i(rst), .ce_i(ce),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat),
    .dat_o(dat_o), .ack_o(ack), .coax_valid_i(cv), .coax_rate_i(cr), .opt_valid_i(ov),
    .opt_rate_i(orr), .vid_word_i(vw), .vid_group_i(vg), .gen_word_i(WG), .gray_word_i(WY),
    .aud_word_i(WA), .aud_locked_i(alk), .embed_contact_n_i(con_n), .coax_rx_en_o(crx),
    .opt_rx_en_o(orx), .coax_tx_o(ctx), .opt_tx_o(otx), .tx_is3g_o(is3g),
    .gen_lock_o(glk), .aud_group_o(agrp), .embed_on_o(eon),
    .input_valid_indicator_output_o(ind));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle; read data lands in rd.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hF);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    // Wait for the answer; only the bench timeout ends a hang.
    do
    begin
      @(posedge clk);
    end
    while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Cut a hang short.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      print_verdict();
    end
  end
  initial
  begin
    {rst, ce, cyc, stb, we, adr, sel, dat} = {3'b110, 46'h0};
    {pres, opres, rate, tag, con_n, alk} = {2'b10, RATE_HD, 3'h0, 2'b11};
    tick(8);
    rst <= 1'b0;
    wb(0, REG_CTRL, 0);
    chk("ctrl_rst", 32'(CTRL_RST), rd);
    wb(0, REG_GROUP, 0);
    chk("group_rst", 32'(GROUP_RST), rd);
    wb(1, REG_CTRL, 32'h4);
    tick(4);
    // Group choices, tag by tag.
    for (int i = 0; i < 9; i++)
    begin
      wb(1, REG_GROUP, i);
      wb(0, REG_GROUP, 0);
      chk("group_rb", i, rd);
      chk("mask", tbl[i], agrp);
      for (int t = 0; t < 5; t++)
      begin
        tag <= 3'(t);
        tick(4);
        chk("tx", (t != 0 && tbl[i][(t+3)%4]) ? WA : WV, ctx);
      end
    end
    $display("done: group table");
    wb(1, REG_GROUP, 9);
    wb(1, REG_GROUP, 0, 4'h0);
    wb(0, REG_GROUP, 0);
    chk("group_keep", 8, rd);
    wb(1, 8'h0C, 32'hFF);
    wb(0, 8'h0C, 0);
    chk("unmapped", 0, rd);
    for (int i = 0; i < 6; i++)
    begin
      wb(1, REG_CTRL, t2[i][6:3]);
      tick(5);
      chk("rx_en", t2[i][2:1], {crx, orx});
      chk("ind", t2[i][0], ind);
    end
    $display("done: control table");
    wb(1, REG_CTRL, 32'h4);
    rate <= RATE_SD;
    // Untagged words from here, so pass, gray and image show plainly.
    tag  <= 3'h0;
    tick(5);
    chk("sd_ind", 0, ind);
    rate <= RATE_3G;
    tick(5);
    chk("is3g", 1, is3g);
    chk("pass", WV, ctx);
    pres <= 1'b0;
    tick(5);
    chk("gray", WY, ctx);
    wb(0, REG_STATUS, 0);
    chk("st_gray", 1, rd[ST_GRAY]);
    tick(GC + 5);
    chk("image", WG, ctx);
    $display("done: loss");
    pres <= 1'b1;
    wb(1, REG_CTRL, 32'h5);
    tick(GC + 10);
    chk("extref_tx", WG, ctx);
    chk("gen_lock", 1, glk);
    wb(1, REG_CTRL, 32'h4);
    // Group choice 8 is still set: group 2 is embedded.
    tag <= 3'h2;
    tick(GC + 10);
    con_n <= 1'b0;
    tick(2);
    con_n <= 1'b1;
    tick(3);
    chk("glitch", 1, eon);
    con_n <= 1'b0;
    tick(DC + 8);
    chk("embed_off", 0, eon);
    chk("tx_off", WV, ctx);
    con_n <= 1'b1;
    tick(DC + 8);
    chk("tx_on", WA, ctx);
    // Unlocked converters leave the external stream untouched.
    alk <= 1'b0;
    tick(5);
    chk("unlocked", WV, ctx);
    alk <= 1'b1;
    tick(2);
    $display("done: contact");
    ce <= 1'b0;
    tick(1);
    snap = ctx;
    tag <= 3'h0;
    tick(3);
    chk("freeze", snap, ctx);
    ce <= 1'b1;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    wb(0, REG_CTRL, 0);
    chk("ctrl_rst2", 32'(CTRL_RST), rd);
    $display("done: freeze and reset");
    print_verdict();
  end
endmodule
bind soaec_top soaec_checker #(.DB_CYCLES(DB_CYCLES)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .ack_o(ack_o),
  .coax_rx_en_o(coax_rx_en_o), .opt_rx_en_o(opt_rx_en_o), .coax_tx_o(coax_tx_o),
  .opt_tx_o(opt_tx_o), .aud_group_o(aud_group_o), .embed_on_o(embed_on_o),
  .embed_contact_n_i(embed_contact_n_i));
